/* File: flash_crc_memory_scan.sv */
// Program-flash CRC scanner with AHB-Lite registers and debugger port.
// Assumes flash, CPU, fuses and debugger all run on hclk; the flash
// returns a word with flash_gnt in the cycle it grants flash_req.
`timescale 1ns/1ps
`default_nettype none

module flash_crc_memory_scan #(
	parameter int FLASH_BYTES = 4096
) (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// Flash read port
	output logic             flash_req,
	output logic [$clog2(FLASH_BYTES/2)-1:0] flash_addr,
	input  wire logic        flash_gnt,
	input  wire logic [15:0] flash_rdata,
	// CPU side
	input  wire logic        cpu_sleep,
	output logic             cpu_stall,
	output logic             cpu_hold,
	output logic             nmi_req,
	// Fuses, static after reset
	input  wire logic [7:0]  boot_end_fuse,
	input  wire logic [7:0]  app_end_fuse,
	input  wire logic        startup_scan_fuse,
	input  wire logic [1:0]  startup_src_fuse,
	// Debugger
	input  wire logic        dbg_connected,
	input  wire logic        dbg_access,
	input  wire logic        dbg_internal,
	input  wire logic        dbg_status_rd,
	input  wire logic        dbg_wr,
	input  wire logic [1:0]  dbg_waddr,
	input  wire logic [7:0]  dbg_wdata,
	output logic [1:0]       dbg_status
);

	localparam int FLASH_WORDS = FLASH_BYTES / 2;
	localparam int AW          = $clog2(FLASH_WORDS);

	if (FLASH_BYTES < 8 || (FLASH_BYTES & (FLASH_BYTES - 1)) != 0)
	begin : g_bad_size
		$error("FLASH_BYTES must be a power of two of at least 8");
	end

	// ==================================================================
	// State
	flash_crc_pkg::scan_state_t state_q;
	flash_crc_pkg::scan_mode_t  mode_q;
	flash_crc_pkg::scan_src_t   src_q;
	logic          enable_q;
	logic          failure_nmi_enable_q;
	logic          ok_q;
	logic          clr_q;
	logic          init_q;
	logic          startup_q;
	logic          single_q;
	logic          halt_q;
	logic          restart_q;
	logic [AW-1:0] addr_q;
	logic [AW-1:0] last_q;
	logic [15:0]   crc_q;
	logic [1:0]    pace_q;
	logic          req_q;
	logic          wr_pend_q;
	logic [1:0]    wr_idx_q;
	logic          nmi_q;
	logic          stall_q;
	logic          hold_q;
	logic [31:0]   hrdata_q;
	logic [1:0]    dbg_status_q;

	// ==================================================================
	// Write merge and event decode
	logic          busy;
	logic          paused;
	logic          ahb_take;
	logic          ahb_mapped;
	logic [1:0]    w_idx;
	logic [7:0]    w_data;
	logic          w_allow;
	logic          wr_ctrl;
	logic          wr_mode;
	logic          wr_stat;
	logic          strobe_ok;
	logic          start_cpu;
	logic          sched;
	logic          cancel;
	logic          release_evt;
	logic          restart;
	logic          boot_start;
	logic          pass;
	logic          fail_nmi;
	logic          prio;
	logic [15:0]   crc_word;
	logic [7:0]    stat_rd;
	logic [7:0]    rd_val;

	assign busy   = (state_q != flash_crc_pkg::ST_IDLE);
	assign paused = cpu_sleep | halt_q;

	assign ahb_take   = hsel & hready & htrans[1];
	assign ahb_mapped = (haddr[31:4] == 28'h0000000) &
		(haddr[3:2] != 2'h3);

	// Debugger writes share the CPU path and checks
	assign w_idx   = dbg_wr ? dbg_waddr : wr_idx_q;
	assign w_data  = dbg_wr ? dbg_wdata : hwdata[7:0];
	assign w_allow = (dbg_wr | wr_pend_q) & ~nmi_q;
	assign wr_ctrl = w_allow & (w_idx == flash_crc_pkg::IDX_MAIN_CTRL);
	assign wr_mode = w_allow & (w_idx == flash_crc_pkg::IDX_MODE_SOURCE);
	assign wr_stat = w_allow & dbg_wr &
		(w_idx == flash_crc_pkg::IDX_STATUS);

	assign strobe_ok = wr_ctrl & w_data[flash_crc_pkg::CTRL_RESET_BIT] &
		(~failure_nmi_enable_q | ~busy);
	assign start_cpu = wr_ctrl & w_data[flash_crc_pkg::CTRL_ENABLE_BIT];
	assign sched     = wr_stat & w_data[flash_crc_pkg::STAT_BUSY_BIT];
	assign cancel    = wr_stat & ~w_data[flash_crc_pkg::STAT_BUSY_BIT];

	assign release_evt = halt_q & ~dbg_access &
		(dbg_internal | dbg_status_rd | ~dbg_connected);
	assign restart    = release_evt & restart_q & busy;
	assign boot_start = ~init_q & startup_scan_fuse;

	assign pass     = (crc_q == flash_crc_pkg::CRC_RESIDUE);
	assign fail_nmi = failure_nmi_enable_q & (
		((state_q == flash_crc_pkg::ST_CHECK) & ~pass) |
		(wr_stat & ~w_data[flash_crc_pkg::STAT_OK_BIT]));
	assign prio = (mode_q == flash_crc_pkg::MODE_PRIORITY) | startup_q;

	// Low byte sits at the lower address, so it goes in first
	assign crc_word = flash_crc_pkg::crc_byte(
		flash_crc_pkg::crc_byte(crc_q, flash_rdata[7:0]),
		flash_rdata[15:8]);

	// ==================================================================
	// Section end
	function automatic logic [AW-1:0] page_end(input logic [7:0] fuse);
		int w;
		w = int'(fuse) * flash_crc_pkg::PAGE_WORDS - 1;
		if (fuse == 8'h00 || w > FLASH_WORDS - 1) begin
			w = FLASH_WORDS - 1;
		end
		return AW'(w);
	endfunction : page_end

	function automatic logic [AW-1:0] sect_end(
		input flash_crc_pkg::scan_src_t s);
		logic [AW-1:0] e;
		case (s)
			flash_crc_pkg::SRC_BOOT:     e = page_end(boot_end_fuse);
			flash_crc_pkg::SRC_BOOT_APP: e = page_end(app_end_fuse);
			default:                     e = AW'(FLASH_WORDS - 1);
		endcase
		return e;
	endfunction : sect_end

	// ==================================================================
	// AHB-Lite slave: zero wait, always OKAY
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q  <= 2'h0;
			hrdata_q  <= 32'h00000000;
		end else begin
			wr_pend_q <= ahb_take & hwrite & ahb_mapped;
			wr_idx_q  <= haddr[3:2];
			if (ahb_take & ~hwrite & ahb_mapped) begin
				hrdata_q <= {24'h000000, rd_val};
			end else begin
				hrdata_q <= 32'h00000000;
			end
		end
	end

	always_comb begin
		stat_rd = 8'h00;
		stat_rd[flash_crc_pkg::STAT_BUSY_BIT] = busy;
		stat_rd[flash_crc_pkg::STAT_OK_BIT]   = ok_q & ~busy;
		rd_val = 8'h00;
		case (haddr[3:2])
			flash_crc_pkg::IDX_MAIN_CTRL: begin
				rd_val[flash_crc_pkg::CTRL_FAILURE_NMI_ENABLE_BIT]  = failure_nmi_enable_q;
				rd_val[flash_crc_pkg::CTRL_ENABLE_BIT] = enable_q;
			end
			flash_crc_pkg::IDX_MODE_SOURCE: begin
				rd_val[flash_crc_pkg::MODE_LSB +: 2] = mode_q;
				rd_val[flash_crc_pkg::SRC_LSB +: 2]  = src_q;
			end
			flash_crc_pkg::IDX_STATUS: rd_val = stat_rd;
			default: rd_val = 8'h00;
		endcase
	end

	// ==================================================================
	// Control registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clr_q  <= 1'b0;
			init_q <= 1'b0;
		end else begin
			clr_q  <= strobe_ok;
			init_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			enable_q <= flash_crc_pkg::ENABLE_RST;
		end else if (clr_q) begin
			enable_q <= flash_crc_pkg::ENABLE_RST;
		end else if (boot_start) begin
			enable_q <= 1'b1;
		end else if (wr_ctrl) begin
			enable_q <= w_data[flash_crc_pkg::CTRL_ENABLE_BIT];
		end
	end

	// Only a system reset clears the enable
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			failure_nmi_enable_q <= flash_crc_pkg::FAILURE_NMI_ENABLE_RST;
		end else if (wr_ctrl & ~busy &
			w_data[flash_crc_pkg::CTRL_FAILURE_NMI_ENABLE_BIT]) begin
			failure_nmi_enable_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_q <= flash_crc_pkg::MODE_RST;
			src_q  <= flash_crc_pkg::SRC_RST;
		end else if (clr_q) begin
			mode_q <= flash_crc_pkg::MODE_RST;
			src_q  <= flash_crc_pkg::SRC_RST;
		end else if (boot_start) begin
			mode_q <= flash_crc_pkg::MODE_SINGLE_BG;
			src_q  <= flash_crc_pkg::scan_src_t'(startup_src_fuse);
		end else if (wr_mode & ~busy) begin
			mode_q <= flash_crc_pkg::scan_mode_t'(
				w_data[flash_crc_pkg::MODE_LSB +: 2]);
			src_q  <= flash_crc_pkg::scan_src_t'(
				w_data[flash_crc_pkg::SRC_LSB +: 2]);
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ok_q <= flash_crc_pkg::OK_RST;
		end else if (clr_q) begin
			ok_q <= flash_crc_pkg::OK_RST;
		end else if (wr_stat) begin
			ok_q <= w_data[flash_crc_pkg::STAT_OK_BIT];
		end else if (state_q == flash_crc_pkg::ST_CHECK) begin
			ok_q <= pass;
		end
	end

	// Sticky until system reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nmi_q <= 1'b0;
		end else if (fail_nmi) begin
			nmi_q <= 1'b1;
		end
	end

	// ==================================================================
	// Debugger hold and restart
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			halt_q <= 1'b0;
		end else if (dbg_access) begin
			halt_q <= 1'b1;
		end else if (release_evt) begin
			halt_q <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			restart_q <= 1'b0;
		end else if (cancel | clr_q | restart) begin
			restart_q <= 1'b0;
		end else if (dbg_access & busy) begin
			restart_q <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dbg_status_q <= 2'h0;
		end else begin
			dbg_status_q <= {stat_rd[flash_crc_pkg::STAT_OK_BIT],
				stat_rd[flash_crc_pkg::STAT_BUSY_BIT]};
		end
	end

	// ==================================================================
	// Scan engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q   <= flash_crc_pkg::ST_IDLE;
			single_q  <= 1'b0;
			startup_q <= 1'b0;
			addr_q    <= '0;
			last_q    <= '0;
			crc_q     <= flash_crc_pkg::CRC_INIT;
			pace_q    <= 2'h0;
			req_q     <= 1'b0;
		end else if (clr_q | cancel) begin
			state_q   <= flash_crc_pkg::ST_IDLE;
			single_q  <= 1'b0;
			startup_q <= 1'b0;
			req_q     <= 1'b0;
		end else if (boot_start | start_cpu | sched | restart) begin
			state_q   <= flash_crc_pkg::ST_RUN;
			single_q  <= sched | (single_q & restart);
			startup_q <= boot_start | (startup_q & restart);
			addr_q    <= '0;
			last_q    <= boot_start ?
				sect_end(flash_crc_pkg::scan_src_t'(startup_src_fuse)) :
				sect_end(src_q);
			crc_q     <= flash_crc_pkg::CRC_INIT;
			pace_q    <= 2'h0;
			req_q     <= 1'b0;
		end else begin
			case (state_q)
				flash_crc_pkg::ST_RUN: begin
					if (paused) begin
						req_q <= 1'b0;
					end else if (req_q & flash_gnt) begin
						crc_q  <= crc_word;
						addr_q <= addr_q + AW'(1);
						req_q  <= 1'b0;
						pace_q <= prio ? flash_crc_pkg::PRIO_GAP :
							flash_crc_pkg::BG_GAP;
						if (addr_q == last_q) begin
							state_q <= flash_crc_pkg::ST_CHECK;
						end
					end else if (!req_q) begin
						if (pace_q == 2'h0) begin
							req_q <= 1'b1;
						end else begin
							pace_q <= pace_q - 2'h1;
						end
					end
				end
				flash_crc_pkg::ST_CHECK: begin
					if (mode_q == flash_crc_pkg::MODE_CONT_BG &&
						enable_q && !single_q && !startup_q) begin
						state_q <= flash_crc_pkg::ST_RUN;
						addr_q  <= '0;
						crc_q   <= flash_crc_pkg::CRC_INIT;
						pace_q  <= 2'h0;
					end else begin
						state_q  <= flash_crc_pkg::ST_IDLE;
						single_q <= 1'b0;
						startup_q <= 1'b0;
					end
				end
				default: begin
					state_q <= flash_crc_pkg::ST_IDLE;
					req_q   <= 1'b0;
				end
			endcase
		end
	end

	// ==================================================================
	// CPU stall and startup hold
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stall_q <= 1'b0;
		end else begin
			stall_q <= (state_q == flash_crc_pkg::ST_RUN) & prio &
				~paused;
		end
	end

	// CPU stays held after a failed startup check until a clear strobe or a debugger cancel
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hold_q <= 1'b1;
		end else if (!init_q) begin
			hold_q <= startup_scan_fuse;
		end else if (startup_q & (state_q == flash_crc_pkg::ST_CHECK) &
			pass) begin
			hold_q <= 1'b0;
		end else if (clr_q | cancel) begin
			hold_q <= 1'b0;
		end
	end

	// ==================================================================
	// Outputs
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign hrdata     = hrdata_q;
	assign flash_req  = req_q;
	assign flash_addr = addr_q;
	assign cpu_stall  = stall_q;
	assign cpu_hold   = hold_q;
	assign nmi_req    = nmi_q;
	assign dbg_status = dbg_status_q;

endmodule : flash_crc_memory_scan

`default_nettype wire

/* File: flash_crc_monitor.sv */
// Port-level assertions for the flash CRC scanner.
// Assumes one clock hclk and asynchronous active-low hresetn.
`timescale 1ns/1ps
`default_nettype none

module flash_crc_monitor #(
	parameter int FLASH_BYTES = 4096
) (
	// Clock and reset
	input wire logic                             hclk,
	input wire logic                             hresetn,
	// Bus
	input wire logic                             hsel,
	input wire logic [1:0]                       htrans,
	input wire logic                             hready,
	input wire logic                             hreadyout,
	input wire logic                             hresp,
	input wire logic [31:0]                      hrdata,
	// Flash and CPU
	input wire logic                             flash_req,
	input wire logic [$clog2(FLASH_BYTES/2)-1:0] flash_addr,
	input wire logic                             flash_gnt,
	input wire logic                             cpu_sleep,
	input wire logic                             cpu_stall,
	input wire logic                             nmi_req,
	// Debugger
	input wire logic                             dbg_connected,
	input wire logic                             dbg_access,
	input wire logic                             dbg_internal,
	input wire logic                             dbg_status_rd,
	input wire logic [1:0]                       dbg_status
);
	localparam int AW = $clog2(FLASH_BYTES / 2);
	logic          phase_q;
	logic [AW-1:0] last_q;

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ==================================================================
	// Helper state: data phase, last word fetched
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase_q <= 1'b0;
		end else begin
			phase_q <= hsel && hready && htrans[1];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_q <= '1;
		end else if (flash_req && flash_gnt) begin
			last_q <= flash_addr;
		end
	end

	// ==================================================================
	// Sequences
	sequence consume_s;
		flash_req && flash_gnt;
	endsequence

	sequence held_s;
		dbg_access ##1 (dbg_connected && !dbg_internal && !dbg_status_rd)[*2];
	endsequence

	// ==================================================================
	// Assertions
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	AST_RDATA_IDLE: assert property (!phase_q |-> hrdata == 32'h0)
		else $error("read data outside data phase");
	AST_NMI_STICKY: assert property (nmi_req |=> nmi_req)
		else $error("nmi request dropped before reset");
	AST_SLEEP_PAUSE: assert property (cpu_sleep[*3] |-> !flash_req)
		else $error("flash fetch while cpu sleeps");
	AST_FETCH_GAP: assert property (consume_s |=> !flash_req)
		else $error("fetch right after a consumed word");
	AST_PRIO_PACE: assert property (consume_s ##0 cpu_stall |=> !flash_req[*2])
		else $error("priority fetch faster than every third cycle");
	AST_DBG_HOLD: assert property (held_s |-> !flash_req)
		else $error("fetch while debugger holds scanner");
	AST_ASCEND: assert property (consume_s |->
		(flash_addr == last_q + 1'b1) || (flash_addr == '0))
		else $error("words not fetched in ascending order");
	AST_ADDR_HOLD: assert property (flash_req && !flash_gnt ##1 flash_req
		|-> $stable(flash_addr))
		else $error("flash address changed while waiting");
	AST_OK_MASKED: assert property (dbg_status != 2'b11)
		else $error("ok copy high while busy");
endmodule : flash_crc_monitor

bind flash_crc_memory_scan flash_crc_monitor #(.FLASH_BYTES(FLASH_BYTES)) u_mon (
	.hclk, .hresetn, .hsel, .htrans, .hready, .hreadyout, .hresp, .hrdata,
	.flash_req, .flash_addr, .flash_gnt, .cpu_sleep, .cpu_stall, .nmi_req,
	.dbg_connected, .dbg_access, .dbg_internal, .dbg_status_rd, .dbg_status
);

`default_nettype wire

/* File: flash_crc_pkg.sv */
// Constants, types and the CRC step shared by the flash CRC scanner.
// Assumes nothing of its surroundings; pure definitions.
`default_nettype none

package flash_crc_pkg;

	// ==================================================================
	// Register indices (byte address is four times the index)
	localparam logic [1:0] IDX_MAIN_CTRL   = 2'h0;
	localparam logic [1:0] IDX_MODE_SOURCE = 2'h1;
	localparam logic [1:0] IDX_STATUS      = 2'h2;

	// ==================================================================
	// Field positions
	localparam int CTRL_RESET_BIT  = 7;
	localparam int CTRL_FAILURE_NMI_ENABLE_BIT  = 1;
	localparam int CTRL_ENABLE_BIT = 0;
	localparam int MODE_LSB        = 4;
	localparam int SRC_LSB         = 0;
	localparam int STAT_OK_BIT     = 1;
	localparam int STAT_BUSY_BIT   = 0;

	// ==================================================================
	// Modes, sources, states
	typedef enum logic [1:0] {
		MODE_PRIORITY  = 2'h0,
		MODE_SPARE     = 2'h1,
		MODE_SINGLE_BG = 2'h2,
		MODE_CONT_BG   = 2'h3
	} scan_mode_t;

	typedef enum logic [1:0] {
		SRC_FULL     = 2'h0,
		SRC_BOOT_APP = 2'h1,
		SRC_BOOT     = 2'h2,
		SRC_SPARE    = 2'h3
	} scan_src_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'h0,
		ST_RUN   = 2'h1,
		ST_CHECK = 2'h2
	} scan_state_t;

	// ==================================================================
	// Reset values, CRC constants, timing counts
	localparam logic       ENABLE_RST  = 1'b0;
	localparam logic       FAILURE_NMI_ENABLE_RST   = 1'b0;
	localparam logic       OK_RST      = 1'b0;
	localparam scan_mode_t MODE_RST    = MODE_PRIORITY;
	localparam scan_src_t  SRC_RST     = SRC_FULL;
	localparam logic [15:0] CRC_POLY    = 16'h1021;
	localparam logic [15:0] CRC_INIT    = 16'hFFFF;
	localparam logic [15:0] CRC_RESIDUE = 16'h0000;
	localparam int         FETCH_PERIOD = 3;
	localparam logic [1:0] PRIO_GAP    = 2'(FETCH_PERIOD - 2);
	localparam logic [1:0] BG_GAP      = 2'h0;
	localparam int         PAGE_WORDS  = 128;

	// One byte through the CRC, most significant bit first
	function automatic logic [15:0] crc_byte(input logic [15:0] c_in,
		input logic [7:0] d);
		logic [15:0] c;
		logic        fb;
		c = c_in;
		fb = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			fb = c[15] ^ d[i];
			c = {c[14:0], 1'b0};
			if (fb) begin
				c = c ^ CRC_POLY;
			end
		end
		return c;
	endfunction : crc_byte

endpackage : flash_crc_pkg

`default_nettype wire

/* File: flash_model.sv */
// Program flash model: grants a request in its own cycle unless stalled.
// Assumes the bench fills mem and drives stall on hclk.
`timescale 1ns/1ps
`default_nettype none

module flash_model #(
	parameter int WORDS = 32
) (
	// Clock
	input  wire logic                     hclk,
	// Read port
	input  wire logic                     flash_req,
	input  wire logic [$clog2(WORDS)-1:0] flash_addr,
	input  wire logic                     stall,
	output logic                          flash_gnt,
	output logic [15:0]                   flash_rdata
);
	logic [15:0] mem [WORDS];
	logic [15:0] junk_q;

	// Data off a grant changes every cycle so stale reads show up
	initial junk_q = 16'h1234;
	always @(posedge hclk) begin
		junk_q <= junk_q + 16'h5A5B;
	end

	assign flash_gnt   = flash_req && !stall;
	assign flash_rdata = flash_gnt ? mem[flash_addr] : junk_q;
endmodule : flash_model

`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the flash CRC scanner.
// Assumes a 64-byte flash with all section fuses zero (whole flash).
`timescale 1ns/1ps
`default_nettype none

module testbench;
	localparam int NW = 32;
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans, dbg_waddr, dbg_status;
	logic [2:0]  hsize;
	logic        flash_req, flash_gnt, cpu_sleep, cpu_stall, cpu_hold;
	logic [4:0]  flash_addr;
	logic [15:0] flash_rdata;
	logic        nmi_req, dbg_connected, dbg_access, dbg_internal;
	logic        dbg_status_rd, dbg_wr, stall, slow_en, startup_en;
	logic [7:0]  dbg_wdata;
	int          miscompares, tests_run;
	integer      seed;

	assign hready = hreadyout;
	initial hclk = 1'b0;
	always #12.5 hclk = ~hclk;
	always @(posedge hclk) begin
		stall <= slow_en && (($random(seed) & 1) != 0);
	end

	flash_crc_memory_scan #(.FLASH_BYTES(64)) u_flash_crc_memory_scan (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .flash_req, .flash_addr,
		.flash_gnt, .flash_rdata, .cpu_sleep, .cpu_stall, .cpu_hold, .nmi_req,
		.boot_end_fuse(8'h00), .app_end_fuse(8'h00),
		.startup_scan_fuse(startup_en), .startup_src_fuse(2'h0),
		.dbg_connected, .dbg_access, .dbg_internal, .dbg_status_rd, .dbg_wr,
		.dbg_waddr, .dbg_wdata, .dbg_status
	);

	flash_model #(.WORDS(NW)) u_flash_model (
		.hclk, .flash_req, .flash_addr, .stall, .flash_gnt, .flash_rdata
	);

	// ==================================================================
	// Expectations and checks
	function automatic logic [15:0] crc8(input logic [15:0] c,
		input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			c = (c[15] ^ b[i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
		end
		return c;
	endfunction : crc8

	function automatic logic [31:0] cfg(input logic [1:0] m,
		input logic [1:0] s);
		return {24'h0, 2'h0, m, 2'h0, s};
	endfunction : cfg

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : conclude

	// ==================================================================
	// Drivers
	task automatic bus(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge hclk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		hsize  <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdc(input string what, input logic [31:0] a,
		input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(what, exp, rd);
	endtask : rdc

	task automatic dpulse(input int k, input logic [1:0] a,
		input logic [7:0] d);
		@(posedge hclk);
		dbg_access    <= (k == 0);
		dbg_internal  <= (k == 1);
		dbg_status_rd <= (k == 2);
		dbg_wr        <= (k == 3);
		dbg_waddr     <= a;
		dbg_wdata     <= d;
		@(posedge hclk);
		dbg_access    <= 1'b0;
		dbg_internal  <= 1'b0;
		dbg_status_rd <= 1'b0;
		dbg_wr        <= 1'b0;
	endtask : dpulse

	task automatic wait_idle;
		for (int i = 0; i < 400; i++) begin
			bus(1'b0, 32'h8, 32'h0);
			if (rd[0] === 1'b0) break;
		end
	endtask : wait_idle

	// Random image, checksum stored high byte first in the last word
	task automatic fill(input logic bad);
		logic [15:0] c;
		c = 16'hFFFF;
		for (int i = 0; i < NW - 1; i++) begin
			u_flash_model.mem[i] = 16'($random(seed));
			c = crc8(crc8(c, u_flash_model.mem[i][7:0]),
				u_flash_model.mem[i][15:8]);
		end
		u_flash_model.mem[NW-1] = {c[7:0], c[15:8]} ^ {15'h0, bad};
	endtask : fill

	// ==================================================================
	// Watchdog
	initial begin
		repeat (40000) @(posedge hclk);
		miscompares++;
		conclude();
	end

	// ==================================================================
	// Scenarios
	initial begin
		seed = 32'h3039;
		hresetn = 1'b0;
		{hsel, hwrite, cpu_sleep, dbg_access, dbg_internal} = 5'h00;
		{dbg_status_rd, dbg_wr, slow_en, startup_en} = 4'h0;
		{haddr, hwdata, htrans, hsize, dbg_waddr, dbg_wdata} = 79'h0;
		dbg_connected = 1'b1;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		rdc("main ctrl", 32'h0, 32'h0);
		rdc("mode src", 32'h4, 32'h0);
		rdc("status", 32'h8, 32'h0);
		chk("no hold", 32'h0, {31'h0, cpu_hold});
		wr(32'hC, 32'hFF);
		rdc("unmapped", 32'hC, 32'h0);
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			fill(1'b0);
			slow_en = i[0];
			wr(32'h4, cfg(2'(i + (i != 0)), 2'(i)));
			wr(32'h0, 32'h1);
			if (i == 2) wr(32'h0, 32'h0);
			wait_idle();
			slow_en = 1'b0;
			chk("status", 32'h2, rd);
			rdc("mode src", 32'h4, cfg(2'(i + (i != 0)), 2'(i)));
		end
		$display("test modes done");
		fill(1'b1);
		wr(32'h4, cfg(2'h2, 2'h0));
		wr(32'h0, 32'h1);
		wr(32'h4, cfg(2'h0, 2'h2));
		wait_idle();
		chk("status bad", 32'h0, rd);
		rdc("mode busy", 32'h4, cfg(2'h2, 2'h0));
		dpulse(3, 2'h2, 8'h02);
		rdc("ok forced", 32'h8, 32'h2);
		$display("test failure done");
		fill(1'b0);
		dpulse(3, 2'h1, 8'h21);
		rdc("dbg mode", 32'h4, cfg(2'h2, 2'h1));
		wr(32'h0, 32'h1);
		repeat (10) @(posedge hclk);
		dpulse(0, 2'h0, 8'h00);
		repeat (40) @(posedge hclk);
		rdc("held busy", 32'h8, 32'h1);
		dpulse(1, 2'h0, 8'h00);
		wait_idle();
		chk("restart", 32'h2, rd);
		wr(32'h0, 32'h1);
		dpulse(0, 2'h0, 8'h00);
		dpulse(3, 2'h2, 8'h00);
		dpulse(2, 2'h0, 8'h00);
		repeat (4) @(posedge hclk);
		bus(1'b0, 32'h8, 32'h0);
		chk("cancel", 32'h0, {31'h0, rd[0]});
		dpulse(0, 2'h0, 8'h00);
		dpulse(3, 2'h2, 8'h01);
		repeat (20) @(posedge hclk);
		bus(1'b0, 32'h8, 32'h0);
		chk("scheduled", 32'h1, {31'h0, rd[0]});
		@(posedge hclk);
		dbg_connected <= 1'b0;
		@(posedge hclk);
		dbg_connected <= 1'b1;
		wait_idle();
		chk("dbg check", 32'h2, rd);
		chk("dbg copy", 32'h2, {30'h0, dbg_status});
		$display("test debugger done");
		wr(32'h4, cfg(2'h0, 2'h0));
		wr(32'h0, 32'h1);
		@(posedge hclk);
		cpu_sleep <= 1'b1;
		repeat (30) @(posedge hclk);
		rdc("asleep", 32'h8, 32'h1);
		cpu_sleep <= 1'b0;
		wait_idle();
		chk("woken", 32'h2, rd);
		$display("test sleep done");
		wr(32'h0, 32'h2);
		dpulse(3, 2'h2, 8'h00);
		repeat (3) @(posedge hclk);
		chk("nmi", 32'h1, {31'h0, nmi_req});
		wr(32'h4, cfg(2'h3, 2'h1));
		rdc("locked", 32'h4, cfg(2'h0, 2'h0));
		@(posedge hclk);
		hresetn <= 1'b0;
		startup_en <= 1'b1;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk("nmi reset", 32'h0, {31'h0, nmi_req});
		chk("held at start", 32'h1, {31'h0, cpu_hold});
		wait_idle();
		chk("startup status", 32'h2, rd);
		chk("startup hold", 32'h0, {31'h0, cpu_hold});
		rdc("startup ctrl", 32'h0, 32'h1);
		rdc("startup mode", 32'h4, cfg(2'h2, 2'h0));
		fill(1'b1);
		wr(32'h0, 32'h3);
		wait_idle();
		chk("fail status", 32'h0, rd);
		chk("fail nmi", 32'h1, {31'h0, nmi_req});
		wr(32'h0, 32'h0);
		chk("nmi held", 32'h1, {31'h0, nmi_req});
		rdc("failure_nmi_enable kept", 32'h0, 32'h3);
		$display("test nmi done");
		conclude();
	end
endmodule : testbench

`default_nettype wire
